// *** inc/irq_power_pkg.sv ***
// shared constants for the interrupt priority and power control block
package irq_power_pkg;
  // ---------------------------------------------------------------
  // register map (word indices; the bus byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] power_control_addr = 8'h87;
  localparam logic [7:0] level_main_addr = 8'hb8;
  localparam logic [7:0] level_timer_two_addr = 8'hf8;
  localparam logic [7:0] status_addr = 8'hfc;
  localparam logic [7:0] vector_addr = 8'hf0;
  localparam logic [7:0] power_control_reset = 8'h00;
  localparam logic [7:0] level_reset = 8'h00;
  localparam logic [7:0] level_main_mask = 8'h7f;
  // ---------------------------------------------------------------
  // power control bit positions
  // ---------------------------------------------------------------
  localparam int baud_doubler_bit = 7;
  localparam int aux_ram_off_bit = 6;
  localparam int latch_strobe_quiet_bit = 5;
  localparam int watchdog_load_permit_bit = 4;
  localparam int user_flag_b_bit = 3;
  localparam int user_flag_a_bit = 2;
  localparam int power_off_request_bit = 1;
  localparam int sleep_request_bit = 0;
  // ---------------------------------------------------------------
  // source numbering: request vector bit index
  // ---------------------------------------------------------------
  localparam int src_count = 15;
  localparam int src_ext0 = 0;
  localparam int src_t0 = 1;
  localparam int src_ext1 = 2;
  localparam int src_t1 = 3;
  localparam int src_uart = 4;
  localparam int src_two_wire = 5;
  localparam int src_cap0 = 6;
  localparam int src_cap1 = 7;
  localparam int src_cap2 = 8;
  localparam int src_cap3 = 9;
  localparam int src_adc = 10;
  localparam int src_cmp0 = 11;
  localparam int src_cmp1 = 12;
  localparam int src_cmp2 = 13;
  localparam int src_t2 = 14;
  // sources able to wake from sleep: ext0, t0, ext1/tick, t1, uart, two-wire
  localparam logic [14:0] wake_sources = 15'h003f;
  // vector base and step: 0003h + 8 * source index
  localparam logic [15:0] vector_base = 16'h0003;
  localparam int vector_step_shift = 3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int clk_hz = 10000000;
  localparam int machine_cycle_clocks = 12;
  localparam int watchdog_restart_machine_cycles = 3;
  localparam int watchdog_restart_clocks =
    watchdog_restart_machine_cycles * machine_cycle_clocks;
  localparam int sample_phase = 9;
endpackage : irq_power_pkg

// *** core/irq_power_ctrl.sv ***
// interrupt priority, polling, vectoring and power control with ahb-lite access
`timescale 1ns/1ps
module irq_power_ctrl #(
  parameter int nsrc = irq_power_pkg::src_count
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // core side
  input wire logic [14:0] irq_flags,
  input wire logic [14:0] irq_enable,
  input wire logic ext0_edge_mode,
  input wire logic ext1_edge_mode,
  input wire logic instr_last_cycle,
  input wire logic reti_pulse,
  input wire logic watchdog_loaded,
  input wire logic watchdog_reset,
  output logic irq_call,
  output logic [15:0] irq_vector,
  output logic [14:0] flag_clear,
  // pins (asynchronous, synchronised inside)
  input wire logic watchdog_disable_pin,
  input wire logic fast_osc_select,
  input wire logic slow_osc_retain,
  // peripheral mode outputs
  output logic baud_doubler,
  output logic aux_ram_off,
  output logic latch_strobe_quiet,
  output logic watchdog_load_permit,
  output logic cpu_halt,
  output logic timer_two_hold,
  output logic pwm_hold_high,
  output logic adc_abort,
  output logic sysclk_stop,
  output logic slow_osc_run,
  output logic restart_hold
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] power_control;
    logic [7:0] level_main;
    logic [7:0] level_t2;
    logic dphase;
    logic dwrite;
    logic [7:0] daddr;
    logic [31:0] rdata;
    logic [3:0] phase;
    logic [14:0] sampled;
    logic act_low;
    logic act_high;
    logic call;
    logic [15:0] vec;
    logic [14:0] clr;
    logic [5:0] restart_cnt;
    logic wd_meta;
    logic wd_sync;
    logic fo_meta;
    logic fo_sync;
    logic so_meta;
    logic so_sync;
  } state_t;

  state_t cur;
  state_t nxt;

  // polling order, highest first, as source indices
  localparam logic [3:0] poll_order [15] = '{
    4'd0, 4'd5, 4'd10, 4'd1, 4'd6, 4'd11, 4'd2, 4'd7,
    4'd12, 4'd3, 4'd8, 4'd13, 4'd4, 4'd9, 4'd14};

  // source level bits in source-index order
  function automatic logic [14:0] level_vec(input logic [7:0] m, input logic [7:0] t);
    logic [14:0] v;
    v = '0;
    v[irq_power_pkg::src_ext0] = m[0];
    v[irq_power_pkg::src_t0] = m[1];
    v[irq_power_pkg::src_ext1] = m[2];
    v[irq_power_pkg::src_t1] = m[3];
    v[irq_power_pkg::src_uart] = m[4];
    v[irq_power_pkg::src_two_wire] = m[5];
    v[irq_power_pkg::src_adc] = m[6];
    v[irq_power_pkg::src_cap0] = t[0];
    v[irq_power_pkg::src_cap1] = t[1];
    v[irq_power_pkg::src_cap2] = t[2];
    v[irq_power_pkg::src_cap3] = t[3];
    v[irq_power_pkg::src_cmp0] = t[4];
    v[irq_power_pkg::src_cmp1] = t[5];
    v[irq_power_pkg::src_cmp2] = t[6];
    v[irq_power_pkg::src_t2] = t[7];
    return v;
  endfunction : level_vec

  // first set bit in polling order; found flag in bit 4
  function automatic logic [4:0] poll_pick(input logic [14:0] req);
    logic [4:0] r;
    r = '0;
    for (int i = 14; i >= 0; i--) begin
      if (req[poll_order[i]]) begin
        r = {1'b1, poll_order[i]};
      end
    end
    return r;
  endfunction : poll_pick

  // vector: 0003h + 8 * source index
  function automatic logic [15:0] vector_of(input logic [3:0] s);
    return irq_power_pkg::vector_base + 16'({s, 3'b000});
  endfunction : vector_of

  logic [14:0] levels;
  logic [14:0] pending;
  logic [14:0] hi_req;
  logic [14:0] lo_req;
  logic [4:0] hi_pick;
  logic [4:0] lo_pick;
  logic [4:0] pick;
  logic pick_high;
  logic blocked;
  logic wake_req;
  logic addr_ok;
  logic [7:0] wbyte;
  logic [7:0] wr_power_control;
  logic [7:0] reg_idx;
  logic power_control_wr;

  always_comb begin
    levels = level_vec(cur.level_main, cur.level_t2);
    pending = cur.sampled & irq_enable;
    hi_req = pending & levels;
    lo_req = pending & ~levels;
    hi_pick = poll_pick(hi_req);
    lo_pick = poll_pick(lo_req);
    // high level wins over low; a high service blocks all, low blocks low
    pick_high = hi_pick[4];
    pick = pick_high ? hi_pick : lo_pick;
    blocked = cur.act_high | (cur.act_low & ~pick_high);
    wake_req = |(pending & irq_power_pkg::wake_sources) &&
               !(cur.act_high || (cur.act_low && !(|(hi_req & irq_power_pkg::wake_sources))));
    // registers sit one per word: the bus byte address is four times the index
    reg_idx = haddr[9:2];
    addr_ok = (reg_idx == irq_power_pkg::power_control_addr) ||
              (reg_idx == irq_power_pkg::level_main_addr) ||
              (reg_idx == irq_power_pkg::level_timer_two_addr) ||
              (reg_idx == irq_power_pkg::status_addr) ||
              (reg_idx == irq_power_pkg::vector_addr);
    wbyte = hwdata[7:0];
    wr_power_control = wbyte;
    power_control_wr = cur.dphase && cur.dwrite && (cur.daddr == irq_power_pkg::power_control_addr);
  end

  always_comb begin
    nxt = cur;
    nxt.call = 1'b0;
    nxt.clr = '0;
    // pin synchronisers
    nxt.wd_meta = watchdog_disable_pin;
    nxt.wd_sync = cur.wd_meta;
    nxt.fo_meta = fast_osc_select;
    nxt.fo_sync = cur.fo_meta;
    nxt.so_meta = slow_osc_retain;
    nxt.so_sync = cur.so_meta;
    // ---------------------------------------------------------------
    // machine-cycle phase and sampling
    // ---------------------------------------------------------------
    nxt.phase = (cur.phase == 4'(irq_power_pkg::machine_cycle_clocks - 1)) ?
                4'd0 : cur.phase + 4'd1;
    if (cur.phase == 4'(irq_power_pkg::sample_phase)) begin
      nxt.sampled = irq_flags;
    end
    // poll at end of machine cycle; a blocked sample is simply overwritten
    if (cur.phase == 4'(irq_power_pkg::machine_cycle_clocks - 1) && pick[4] &&
        !blocked && instr_last_cycle && cur.restart_cnt == '0) begin
      nxt.call = 1'b1;
      nxt.vec = vector_of(pick[3:0]);
      if (pick_high) nxt.act_high = 1'b1;
      else nxt.act_low = 1'b1;
      nxt.clr[irq_power_pkg::src_t0] = (pick[3:0] == 4'(irq_power_pkg::src_t0));
      nxt.clr[irq_power_pkg::src_t1] = (pick[3:0] == 4'(irq_power_pkg::src_t1));
      nxt.clr[irq_power_pkg::src_ext0] =
        (pick[3:0] == 4'(irq_power_pkg::src_ext0)) && ext0_edge_mode;
      nxt.clr[irq_power_pkg::src_ext1] =
        (pick[3:0] == 4'(irq_power_pkg::src_ext1)) && ext1_edge_mode;
      nxt.sampled[pick[3:0]] = 1'b0;
    end
    if (reti_pulse) begin
      if (cur.act_high) nxt.act_high = 1'b0;
      else nxt.act_low = 1'b0;
    end
    // ---------------------------------------------------------------
    // bus: address phase capture, data phase write
    // ---------------------------------------------------------------
    nxt.dphase = hsel && hready && htrans[1];
    nxt.dwrite = hwrite;
    nxt.daddr = reg_idx;
    if (cur.dphase && cur.dwrite) begin
      case (cur.daddr)
        irq_power_pkg::power_control_addr: begin
          // whole byte only; power-off refused while watchdog pin low
          nxt.power_control = wr_power_control;
          nxt.power_control[irq_power_pkg::power_off_request_bit] =
            wr_power_control[irq_power_pkg::power_off_request_bit] & cur.wd_sync;
        end
        irq_power_pkg::level_main_addr: nxt.level_main = wbyte & irq_power_pkg::level_main_mask;
        irq_power_pkg::level_timer_two_addr: nxt.level_t2 = wbyte;
        default: ;
      endcase
    end
    // load permit clears on watchdog load; software setting wins the same cycle
    if (watchdog_loaded && !(power_control_wr && wr_power_control[irq_power_pkg::watchdog_load_permit_bit])) begin
      nxt.power_control[irq_power_pkg::watchdog_load_permit_bit] = 1'b0;
    end
    // wake from sleep by an unblocked enabled wake source; a software set in the
    // same cycle wins, the sleep ends again one clock later while the source stays pending
    if (cur.power_control[irq_power_pkg::sleep_request_bit] && wake_req &&
        !(power_control_wr && wr_power_control[irq_power_pkg::sleep_request_bit])) begin
      nxt.power_control[irq_power_pkg::sleep_request_bit] = 1'b0;
    end
    if (nxt.dphase && !hwrite) begin
      case (reg_idx)
        irq_power_pkg::power_control_addr: nxt.rdata = {24'h0, cur.power_control};
        irq_power_pkg::level_main_addr: nxt.rdata = {24'h0, cur.level_main};
        irq_power_pkg::level_timer_two_addr: nxt.rdata = {24'h0, cur.level_t2};
        irq_power_pkg::status_addr: nxt.rdata = {15'h0, cur.act_high, cur.act_low, cur.sampled};
        irq_power_pkg::vector_addr: nxt.rdata = {16'h0, cur.vec};
        default: nxt.rdata = 32'h0;
      endcase
    end
    // ---------------------------------------------------------------
    // watchdog reset: clears power control, both level registers and the active flags, holds restart 3 machine cycles
    // ---------------------------------------------------------------
    if (cur.restart_cnt != '0) nxt.restart_cnt = cur.restart_cnt - 6'd1;
    if (watchdog_reset) begin
      nxt.power_control = irq_power_pkg::power_control_reset;
      nxt.level_main = irq_power_pkg::level_reset;
      nxt.level_t2 = irq_power_pkg::level_reset;
      nxt.act_low = 1'b0;
      nxt.act_high = 1'b0;
      nxt.restart_cnt = 6'(irq_power_pkg::watchdog_restart_clocks);
    end
  end

  // external reset lengths (24 periods / 1 us..10 ms) are the driver's duty
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs: all registered except hreadyout and hresp, which are tied off
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0;
      irq_call <= 1'b0;
      irq_vector <= 16'h0;
      flag_clear <= 15'h0;
      baud_doubler <= 1'b0;
      aux_ram_off <= 1'b0;
      latch_strobe_quiet <= 1'b0;
      watchdog_load_permit <= 1'b0;
      cpu_halt <= 1'b0;
      timer_two_hold <= 1'b0;
      pwm_hold_high <= 1'b0;
      adc_abort <= 1'b0;
      sysclk_stop <= 1'b0;
      slow_osc_run <= 1'b0;
      restart_hold <= 1'b0;
    end else begin
      hrdata <= nxt.rdata;
      irq_call <= nxt.call;
      irq_vector <= nxt.vec;
      flag_clear <= nxt.clr;
      baud_doubler <= nxt.power_control[irq_power_pkg::baud_doubler_bit];
      aux_ram_off <= nxt.power_control[irq_power_pkg::aux_ram_off_bit];
      latch_strobe_quiet <= nxt.power_control[irq_power_pkg::latch_strobe_quiet_bit];
      watchdog_load_permit <= nxt.power_control[irq_power_pkg::watchdog_load_permit_bit];
      // halt the core while sleeping or off; its registers stay frozen
      cpu_halt <= nxt.power_control[irq_power_pkg::sleep_request_bit] |
                  nxt.power_control[irq_power_pkg::power_off_request_bit];
      timer_two_hold <= nxt.power_control[irq_power_pkg::sleep_request_bit];
      pwm_hold_high <= nxt.power_control[irq_power_pkg::sleep_request_bit];
      adc_abort <= nxt.power_control[irq_power_pkg::sleep_request_bit];
      // timers 0/1, watchdog, serial ports and tick have no hold line
      sysclk_stop <= nxt.power_control[irq_power_pkg::power_off_request_bit];
      slow_osc_run <= !cur.fo_sync &&
        (!nxt.power_control[irq_power_pkg::power_off_request_bit] || cur.so_sync);
      restart_hold <= nxt.restart_cnt != '0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // unmapped reads return zero; these inputs carry nothing this block needs
  logic unused_ok;
  assign unused_ok = addr_ok ^ (|hsize) ^ (|haddr[31:10]) ^ (|haddr[1:0]);
endmodule : irq_power_ctrl

// *** sim/irq_power_asserts.sv ***
// concurrent checks on the ports of the interrupt and power control block
`timescale 1ns/1ps
module irq_power_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // core side
  input wire logic instr_last_cycle,
  input wire logic watchdog_loaded,
  input wire logic watchdog_reset,
  input wire logic irq_call,
  input wire logic [15:0] irq_vector,
  input wire logic [14:0] flag_clear,
  // pins and mode outputs
  input wire logic watchdog_disable_pin,
  input wire logic slow_osc_retain,
  input wire logic watchdog_load_permit,
  input wire logic cpu_halt,
  input wire logic timer_two_hold,
  input wire logic pwm_hold_high,
  input wire logic adc_abort,
  input wire logic sysclk_stop,
  input wire logic slow_osc_run,
  input wire logic restart_hold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // length of the current restart hold, too long for a repetition
  logic [7:0] hold_cnt;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_cnt <= 8'h00;
    end else begin
      hold_cnt <= restart_hold ? hold_cnt + 8'h01 : 8'h00;
    end
  end
  property p_vector;
    irq_call |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073;
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");
  property p_clear;
    |flag_clear |-> irq_call && $onehot(flag_clear) && flag_clear[14:4] == 11'h000;
  endproperty
  a_clear: assert property (p_clear) else $error("bad flag clear");
  property p_boundary;
    irq_call |-> $past(instr_last_cycle);
  endproperty
  a_boundary: assert property (p_boundary) else $error("call mid instruction");
  property p_idle;
    timer_two_hold |-> pwm_hold_high && adc_abort && cpu_halt;
  endproperty
  a_idle: assert property (p_idle) else $error("idle outputs split");
  property p_halt;
    cpu_halt |-> timer_two_hold || sysclk_stop;
  endproperty
  a_halt: assert property (p_halt) else $error("halt without mode");
  property p_off_pin;
    $rose(sysclk_stop) |-> $past(watchdog_disable_pin, 3);
  endproperty
  a_off_pin: assert property (p_off_pin) else $error("off with pin low");
  property p_slow;
    sysclk_stop && slow_osc_run |-> $past(slow_osc_retain, 3);
  endproperty
  a_slow: assert property (p_slow) else $error("slow osc kept");
  property p_permit;
    watchdog_loaded |-> ##[1:3] !watchdog_load_permit;
  endproperty
  a_permit: assert property (p_permit) else $error("permit not cleared");
  property p_restart;
    watchdog_reset |-> ##[1:3] restart_hold;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart hold");
  property p_restart_len;
    $fell(restart_hold) |-> hold_cnt == 8'h24;
  endproperty
  a_restart_len: assert property (p_restart_len) else $error("hold length");
  c_call: cover property (irq_call);
  c_idle: cover property ($rose(timer_two_hold));
  c_restart: cover property ($fell(restart_hold));
endmodule : irq_power_asserts
bind irq_power_ctrl irq_power_asserts irq_power_asserts_inst (
  .clk, .sys_rst, .instr_last_cycle, .watchdog_loaded, .watchdog_reset,
  .irq_call, .irq_vector, .flag_clear, .watchdog_disable_pin, .slow_osc_retain,
  .watchdog_load_permit, .cpu_halt, .timer_two_hold, .pwm_hold_high,
  .adc_abort, .sysclk_stop, .slow_osc_run, .restart_hold
);

// *** sim/core_side_model.sv ***
// far side: peripheral request flags and the core's service routine
`timescale 1ns/1ps
module core_side_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bench control
  input wire logic [14:0] raise,
  input wire logic [7:0] lat,
  // block side
  input wire logic irq_call,
  input wire logic [15:0] irq_vector,
  input wire logic [14:0] flag_clear,
  output logic [14:0] irq_flags,
  output logic reti_pulse
);
  logic [3:0] src;
  logic [7:0] cnt;
  // the routine clears its flag in the same clock as its return pulse, so a slow lat
  // keeps the source pending for the whole service unless flag_clear cleared it at the call
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_flags <= 15'h0000;
      cnt <= 8'h00;
      src <= 4'h0;
      reti_pulse <= 1'h0;
    end else begin
      reti_pulse <= 1'h0;
      irq_flags <= (irq_flags | raise) & ~flag_clear;
      if (irq_call) begin
        src <= 4'((irq_vector - 16'h0003) >> 3);
        cnt <= lat;
      end else if (cnt == 8'h01) begin
        irq_flags[src] <= 1'h0;
        reti_pulse <= 1'h1;
        cnt <= 8'h00;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : core_side_model

// *** sim/tb_top.sv ***
// self-checking bench for the interrupt priority and power control block
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] power_control_idx = 8'h87;
  localparam logic [7:0] level_main_idx = 8'hb8;
  localparam logic [7:0] level_two_idx = 8'hf8;
  int ord[15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
  int n_mismatch = 0;
  int tests_run = 0;
  logic clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [14:0] raise = 15'h0000, irq_enable = 15'h7fff, irq_flags, flag_clear;
  logic [7:0] lat = 8'h03;
  logic ext0_edge_mode = 1'h1, ext1_edge_mode = 1'h1, instr_last_cycle = 1'h1;
  logic watchdog_loaded = 1'h0, watchdog_reset = 1'h0, watchdog_disable_pin = 1'h0;
  logic fast_osc_select = 1'h0, slow_osc_retain = 1'h1;
  logic hreadyout, hresp, reti_pulse, irq_call, baud_doubler, aux_ram_off;
  logic latch_strobe_quiet, watchdog_load_permit, cpu_halt, timer_two_hold;
  logic pwm_hold_high, adc_abort, sysclk_stop, slow_osc_run, restart_hold;
  logic [15:0] irq_vector;
  always #50 clk = ~clk;
  irq_power_ctrl irq_power_ctrl_inst (.hready(hreadyout), .*);
  core_side_model core_side_model_inst (.*);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic fail(input string m);
    n_mismatch++;
    $display("Error at %0t: %s", $time, m);
    if (m == "timeout") conclude();
  endtask : fail
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) fail($sformatf("register %h expected %h", g, e));
  endtask : chk_reg
  task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) fail($sformatf("output %h expected %h", g, e));
  endtask : chk_pin
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // master waits on hready in both phases; byte address is four times the index
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {22'h000000, a, 2'h0};
    hwrite <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 20);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 40);
    rdat = hrdata;
    if (n >= 40) fail("timeout");
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'h0, 8'h00);
    chk_reg(rdat, e);
  endtask : rd
  task automatic fire(input logic [14:0] v);
    raise <= v;
    @(posedge clk);
    raise <= 15'h0000;
  endtask : fire
  task automatic wait_call(input logic [15:0] e);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 600) fail("timeout");
    end while (irq_call !== 1'h1);
    chk_pin(irq_vector, e);
  endtask : wait_call
  task automatic do_reset(input int k);
    sys_rst <= 1'h1;
    tick(k);
    sys_rst <= 1'h0;
  endtask : do_reset
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    do_reset(8);
    rd(power_control_idx, 32'h0);
    rd(level_main_idx, 32'h0);
    rd(level_two_idx, 32'h0);
    rd(8'h10, 32'h0);
    bus(power_control_idx, 1'h1, 8'hec);
    rd(power_control_idx, 32'hec);
    tick(2);
    chk_pin(16'({baud_doubler, aux_ram_off, latch_strobe_quiet, cpu_halt}), 16'he);
    bus(level_main_idx, 1'h1, 8'hff);
    rd(level_main_idx, 32'h7f);
    bus(level_two_idx, 1'h1, 8'ha5);
    rd(level_two_idx, 32'ha5);
    bus(power_control_idx, 1'h1, 8'h10);
    tick(2);
    chk_pin(16'(watchdog_load_permit), 16'h1);
    watchdog_loaded <= 1'h1;
    @(posedge clk);
    watchdog_loaded <= 1'h0;
    tick(3);
    chk_pin(16'(watchdog_load_permit), 16'h0);
    rd(power_control_idx, 32'h0);
    $display("test registers done");
    bus(level_main_idx, 1'h1, 8'h00);
    bus(level_two_idx, 1'h1, 8'h00);
    fire(15'h7fff);
    for (int k = 0; k < 15; k++) wait_call(16'h0003 + 16'(ord[k] * 8));
    $display("test polling order done");
    tick(20);
    lat <= 8'h28;
    bus(level_main_idx, 1'h1, 8'h10);
    fire(15'h0011);
    wait_call(16'h0023);
    wait_call(16'h0003);
    tick(60);
    bus(level_main_idx, 1'h1, 8'h00);
    for (int m = 0; m < 2; m++) begin
      ext0_edge_mode <= m[0];
      fire(15'h0001);
      wait_call(16'h0003);
      @(posedge clk);
      chk_pin(16'(irq_flags[0]), 16'(!m[0]));
      tick(60);
    end
    $display("test levels and acknowledge done");
    bus(power_control_idx, 1'h1, 8'h01);
    tick(2);
    chk_pin(16'({cpu_halt, timer_two_hold, pwm_hold_high, adc_abort}), 16'hf);
    fire(15'h0002);
    wait_call(16'h000b);
    rd(power_control_idx, 32'h0);
    chk_pin(16'(cpu_halt), 16'h0);
    tick(60);
    $display("test idle done");
    instr_last_cycle <= 1'h0;
    fire(15'h0002);
    tick(30);
    chk_pin(16'(irq_call), 16'h0);
    rd(8'hfc, 32'h0000_0002);
    instr_last_cycle <= 1'h1;
    wait_call(16'h000b);
    tick(60);
    $display("test instruction boundary done");
    bus(power_control_idx, 1'h1, 8'h02);
    rd(power_control_idx, 32'h0);
    watchdog_disable_pin <= 1'h1;
    tick(4);
    bus(power_control_idx, 1'h1, 8'h02);
    tick(3);
    chk_pin(16'({sysclk_stop, cpu_halt, slow_osc_run}), 16'h7);
    slow_osc_retain <= 1'h0;
    tick(4);
    chk_pin(16'(slow_osc_run), 16'h0);
    do_reset(24);
    slow_osc_retain <= 1'h1;
    rd(power_control_idx, 32'h0);
    $display("test power down done");
    bus(power_control_idx, 1'h1, 8'he0);
    bus(level_main_idx, 1'h1, 8'h03);
    watchdog_reset <= 1'h1;
    @(posedge clk);
    watchdog_reset <= 1'h0;
    n = 0;
    while (restart_hold !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) fail("timeout");
    n = 0;
    while (restart_hold === 1'h1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk_pin(16'(n), 16'h0024);
    rd(power_control_idx, 32'h0);
    rd(level_main_idx, 32'h0);
    $display("test watchdog restart done");
    conclude();
  end
endmodule : tb_top
